// ### design/ccl_comparator_control.sv
// Register file, synchroniser and event logic of the comparator control
`default_nettype none

module ccl_comparator_control
  import ccl_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic [CCL_ADDR_W-1:0]       i_addr,
  input  wire logic [CCL_DATA_W-1:0]       i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic [CCL_DATA_W-1:0]            o_rdata,
  input  wire logic [CCL_LEVEL_W-1:0]      i_positive_level,
  input  wire logic [CCL_LEVEL_W-1:0]      i_negative_level,
  input  wire ccl_channel_levels_type      i_channel_levels,
  input  wire logic                        i_converter_enable,
  input  wire logic [1:0]                  i_channel_select,
  input  wire logic                        i_global_irq_enable,
  input  wire logic                        i_irq_vector_ack,
  input  wire logic                        i_positive_pin,
  input  wire logic                        i_negative_pin,
  output logic [1:0]                       o_pin_inputs,
  output logic [1:0]                       o_buffer_off,
  output logic                             o_comparator_power_off,
  output logic                             o_bandgap_select,
  output logic                             o_irq_request,
  output logic [CCL_DATA_W-1:0]            o_analog_control_b,
  output logic [CCL_DATA_W-1:0]            o_digital_input_disable
);

  // ****************************************
  // Functions
  // ****************************************

  // Event decode from previous and current result
  function automatic logic event_hit(
    input ccl_event_mode_type mode,
    input logic               prev,
    input logic               cur
  );
    logic hit;
    hit = 1'b0;
    case (mode)
      CCL_MODE_TOGGLE:   hit = prev ^ cur;
      CCL_MODE_FALLING:  hit = prev & ~cur;
      CCL_MODE_RISING:   hit = ~prev & cur;
      CCL_MODE_RESERVED: hit = 1'b0;
      default:           hit = 1'b0;
    endcase
    return hit;
  endfunction : event_hit

  // Masked register update
  function automatic logic [CCL_DATA_W-1:0] masked_write(
    input logic [CCL_DATA_W-1:0] old_val,
    input logic [CCL_DATA_W-1:0] new_val,
    input logic [CCL_DATA_W-1:0] wmask
  );
    return (old_val & ~wmask) | (new_val & wmask);
  endfunction : masked_write

  // ****************************************
  // Declarations
  // ****************************************
  logic [CCL_DATA_W-1:0] acb_q;
  logic [CCL_DATA_W-1:0] acb_d;
  logic [CCL_DATA_W-1:0] did_q;
  logic [CCL_DATA_W-1:0] did_d;
  logic                  cmp_disable_q;
  logic                  cmp_disable_d;
  logic                  bandgap_q;
  logic                  bandgap_d;
  logic                  irq_en_q;
  logic                  irq_en_d;
  ccl_event_mode_type    mode_q;
  ccl_event_mode_type    mode_d;
  logic                  flag_q;
  logic                  flag_d;
  logic                  res_sync1_q;
  logic                  res_sync2_q;
  logic                  res_prev_q;
  logic [1:0]            pin_sync1_q;
  logic [1:0]            pin_sync2_q;
  logic [1:0]            pin_in_q;
  logic [1:0]            pin_in_d;
  ccl_state_type         state_q;
  ccl_state_type         state_d;
  logic [1:0]            fill_cnt_q;
  logic [1:0]            fill_cnt_d;
  logic [CCL_DATA_W-1:0] rdata_q;
  logic [CCL_DATA_W-1:0] rdata_d;

  wire logic             sel_acb;
  wire logic             sel_ccs;
  wire logic             sel_did;
  wire logic             wr_acb;
  wire logic             wr_ccs;
  wire logic             wr_did;
  wire logic             neg_mux_enable;
  wire logic             raw_result;
  wire logic             event_seen;
  wire logic             flag_set;
  wire logic             flag_clr;
  wire ccl_ccs_type      ccs_view;
  wire ccl_ccs_type      ccs_wr;
  wire ccl_input_sel_type input_sel;
  wire logic [CCL_DATA_W-1:0] read_mux;

  // ****************************************
  // Address decode
  // ****************************************

  // Register selects and write strobes
  assign sel_acb = (i_addr == CCL_OFS_ANALOG_CONTROL_B);
  assign sel_ccs = (i_addr == CCL_OFS_COMPARATOR_CONTROL_STATUS);
  assign sel_did = (i_addr == CCL_OFS_DIGITAL_INPUT_DISABLE);
  assign wr_acb  = i_wr && sel_acb;
  assign wr_ccs  = i_wr && sel_ccs;
  assign wr_did  = i_wr && sel_did;
  assign ccs_wr  = ccl_ccs_type'(i_wdata);

  // ****************************************
  // Register writes
  // ****************************************

  // Converter control b: bits 4..3 stay zero
  assign acb_d = wr_acb ? masked_write(acb_q, i_wdata, CCL_ACB_WMASK) : acb_q;

  // Buffer disables: bits 7..6 stay zero
  assign did_d = wr_did ? masked_write(did_q, i_wdata, CCL_DID_WMASK) : did_q;

  // Control fields; result and reserved bits not stored
  assign cmp_disable_d = wr_ccs ? ccs_wr.comparator_disable : cmp_disable_q;
  assign bandgap_d     = wr_ccs ? ccs_wr.bandgap_select : bandgap_q;
  assign irq_en_d      = wr_ccs ? ccs_wr.comparator_irq_enable : irq_en_q;
  assign mode_d        = wr_ccs ? ccs_wr.event_mode_select : mode_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      acb_q         <= CCL_ACB_RESET;
      did_q         <= CCL_DID_RESET;
      cmp_disable_q <= 1'b0;
      bandgap_q     <= 1'b0;
      irq_en_q      <= 1'b0;
      mode_q        <= CCL_MODE_TOGGLE;
    end else begin
      acb_q         <= acb_d;
      did_q         <= did_d;
      cmp_disable_q <= cmp_disable_d;
      bandgap_q     <= bandgap_d;
      irq_en_q      <= irq_en_d;
      mode_q        <= mode_d;
    end
  end

  // ****************************************
  // Analog input routing
  // ****************************************

  // Channel path needs mux enable and converter switched off
  assign neg_mux_enable = acb_q[CCL_ACB_NEG_MUX_EN_BIT];
  assign input_sel.powered          = ~cmp_disable_q;
  assign input_sel.bandgap_select   = bandgap_q;
  assign input_sel.neg_from_channel = neg_mux_enable && !i_converter_enable;
  assign input_sel.channel_select   = i_channel_select;

  ccl_input_compare u_input_compare (
    .i_sel            (input_sel),
    .i_positive_level (i_positive_level),
    .i_negative_level (i_negative_level),
    .i_channel_levels (i_channel_levels),
    .o_raw_result     (raw_result)
  );

  // ****************************************
  // Result synchroniser
  // ****************************************

  // Two stages, then one history stage for edge detection
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      res_sync1_q <= 1'b0;
      res_sync2_q <= 1'b0;
      res_prev_q  <= 1'b0;
    end else begin
      res_sync1_q <= raw_result;
      res_sync2_q <= res_sync1_q;
      res_prev_q  <= res_sync2_q;
    end
  end

  // ****************************************
  // Synchroniser fill tracking
  // ****************************************

  // Hold off events while powered down or refilling
  always_comb begin
    state_d    = state_q;
    fill_cnt_d = fill_cnt_q;
    case (state_q)
      CCL_ST_OFF: begin
        fill_cnt_d = 2'h0;
        if (!cmp_disable_q) begin
          state_d = CCL_ST_FILL;
        end
      end
      CCL_ST_FILL: begin
        fill_cnt_d = fill_cnt_q + 2'h1;
        if (cmp_disable_q) begin
          state_d = CCL_ST_OFF;
        end else if (fill_cnt_q == CCL_FILL_CYCLES) begin
          state_d = CCL_ST_RUN;
        end
      end
      CCL_ST_RUN: begin
        if (cmp_disable_q) begin
          state_d = CCL_ST_OFF;
        end
      end
      default: begin
        state_d    = CCL_ST_OFF;
        fill_cnt_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q    <= CCL_ST_OFF;
      fill_cnt_q <= 2'h0;
    end else begin
      state_q    <= state_d;
      fill_cnt_q <= fill_cnt_d;
    end
  end

  // ****************************************
  // Event flag
  // ****************************************

  // Edge of synchronised result against mode
  assign event_seen = event_hit(mode_q, res_prev_q, res_sync2_q);
  assign flag_set   = event_seen && (state_q == CCL_ST_RUN);

  // Vector execution or write of one clears
  assign flag_clr = i_irq_vector_ack || (wr_ccs && i_wdata[CCL_CCS_FLAG_BIT]);

  // Set wins over a clear in the same cycle
  assign flag_d = flag_set || (flag_q && !flag_clr);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Request only with local and global enables
  assign o_irq_request = flag_q && irq_en_q && i_global_irq_enable;

  // ****************************************
  // Digital pin inputs
  // ****************************************

  // Pads are asynchronous: two stages before gating
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_sync1_q <= 2'h0;
      pin_sync2_q <= 2'h0;
    end else begin
      pin_sync1_q <= {i_negative_pin, i_positive_pin};
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // Disabled buffer reads zero
  assign pin_in_d[CCL_DID_NEG_PIN_BIT] = pin_sync2_q[CCL_DID_NEG_PIN_BIT]
                                         && !did_q[CCL_DID_NEG_PIN_BIT];
  assign pin_in_d[CCL_DID_POS_PIN_BIT] = pin_sync2_q[CCL_DID_POS_PIN_BIT]
                                         && !did_q[CCL_DID_POS_PIN_BIT];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_in_q <= 2'h0;
    end else begin
      pin_in_q <= pin_in_d;
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Live view of control and status; reserved bit reads zero
  assign ccs_view.comparator_disable    = cmp_disable_q;
  assign ccs_view.bandgap_select        = bandgap_q;
  assign ccs_view.compare_result_bit    = res_sync2_q;
  assign ccs_view.comparator_event_flag = flag_q;
  assign ccs_view.comparator_irq_enable = irq_en_q;
  assign ccs_view.reserved              = 1'b0;
  assign ccs_view.event_mode_select     = mode_q;

  // Unmapped offsets read zero
  assign read_mux = sel_acb ? acb_q :
                    sel_ccs ? CCL_DATA_W'(ccs_view) :
                    sel_did ? did_q : CCL_RD_NONE;

  // Data stand only in the cycle after the strobe
  assign rdata_d = i_rd ? read_mux : CCL_RD_NONE;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= CCL_RD_NONE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Register-driven controls to pads, core and converter
  assign o_rdata                 = rdata_q;
  assign o_pin_inputs            = pin_in_q;
  assign o_buffer_off            = did_q[1:0];
  assign o_comparator_power_off  = cmp_disable_q;
  assign o_bandgap_select        = bandgap_q;
  assign o_analog_control_b      = acb_q;
  assign o_digital_input_disable = did_q;

endmodule : ccl_comparator_control

`default_nettype wire

// ### design/ccl_input_compare.sv
// Input routing and raw comparison of the comparator core
`default_nettype none

module ccl_input_compare
  import ccl_pkg::*;
(
  input  wire ccl_input_sel_type           i_sel,
  input  wire logic [CCL_LEVEL_W-1:0]      i_positive_level,
  input  wire logic [CCL_LEVEL_W-1:0]      i_negative_level,
  input  wire ccl_channel_levels_type      i_channel_levels,
  output logic                             o_raw_result
);

  // ****************************************
  // Input selection
  // ****************************************
  wire logic [CCL_LEVEL_W-1:0] pos_level;
  wire logic [CCL_LEVEL_W-1:0] neg_level;

  // Bandgap replaces the positive pin when selected
  assign pos_level = i_sel.bandgap_select ? CCL_BANDGAP_LEVEL : i_positive_level;

  // Channel replaces negative pin only when the mux path is allowed
  assign neg_level = i_sel.neg_from_channel ? i_channel_levels[i_sel.channel_select]
                                            : i_negative_level;

  // ****************************************
  // Comparison
  // ****************************************
  // High only while strictly above; unpowered core reads low
  assign o_raw_result = i_sel.powered && (pos_level > neg_level);

endmodule : ccl_input_compare

`default_nettype wire

// ### design/ccl_pkg.sv
// Shared constants and types for the comparator control logic
`default_nettype none

package ccl_pkg;

  // ****************************************
  // Bus and data widths
  // ****************************************
  localparam int CCL_ADDR_W  = 5;
  localparam int CCL_DATA_W  = 8;
  localparam int CCL_LEVEL_W = 10;
  localparam int CCL_NUM_CH  = 4;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [CCL_ADDR_W-1:0] CCL_OFS_ANALOG_CONTROL_B         = 5'h03;
  localparam logic [CCL_ADDR_W-1:0] CCL_OFS_COMPARATOR_CONTROL_STATUS = 5'h08;
  localparam logic [CCL_ADDR_W-1:0] CCL_OFS_DIGITAL_INPUT_DISABLE     = 5'h14;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [CCL_DATA_W-1:0] CCL_ACB_RESET = 8'h00;
  localparam logic [CCL_DATA_W-1:0] CCL_ACB_WMASK = 8'he7;
  localparam logic [CCL_DATA_W-1:0] CCL_DID_RESET = 8'h00;
  localparam logic [CCL_DATA_W-1:0] CCL_DID_WMASK = 8'h3f;
  localparam logic [CCL_DATA_W-1:0] CCL_RD_NONE   = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CCL_ACB_NEG_MUX_EN_BIT = 6;
  localparam int CCL_DID_NEG_PIN_BIT    = 1;
  localparam int CCL_DID_POS_PIN_BIT    = 0;
  localparam int CCL_CCS_FLAG_BIT       = 4;

  // ****************************************
  // Timing and fixed levels
  // ****************************************
  // Last refill count; the result synchroniser refill state lasts one cycle more than this after power-up
  localparam logic [1:0] CCL_FILL_CYCLES = 2'h2;
  // Digital stand-in for the bandgap level; value arbitrary
  localparam logic [CCL_LEVEL_W-1:0] CCL_BANDGAP_LEVEL = 10'h1c2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CCL_MODE_TOGGLE   = 2'h0,
    CCL_MODE_RESERVED = 2'h1,
    CCL_MODE_FALLING  = 2'h2,
    CCL_MODE_RISING   = 2'h3
  } ccl_event_mode_type;

  typedef enum logic [2:0] {
    CCL_ST_OFF  = 3'h1,
    CCL_ST_FILL = 3'h2,
    CCL_ST_RUN  = 3'h4
  } ccl_state_type;

  // Comparator control and status register layout
  typedef struct packed {
    logic               comparator_disable;
    logic               bandgap_select;
    logic               compare_result_bit;
    logic               comparator_event_flag;
    logic               comparator_irq_enable;
    logic               reserved;
    ccl_event_mode_type event_mode_select;
  } ccl_ccs_type;

  // Input routing handed to the analog compare stage
  typedef struct packed {
    logic       powered;
    logic       bandgap_select;
    logic       neg_from_channel;
    logic [1:0] channel_select;
  } ccl_input_sel_type;

  typedef logic [CCL_NUM_CH-1:0][CCL_LEVEL_W-1:0] ccl_channel_levels_type;

endpackage : ccl_pkg

`default_nettype wire

// ### dv/ccl_analog_model.sv
// Behavioural model of the analog comparator's pad and channel levels and pad reads
`default_nettype none

module ccl_analog_model
  import ccl_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic [CCL_LEVEL_W-1:0] i_set_pos,
  input  wire logic [CCL_LEVEL_W-1:0] i_set_neg,
  input  wire ccl_channel_levels_type i_set_ch,
  output logic [CCL_LEVEL_W-1:0]      o_positive_level,
  output logic [CCL_LEVEL_W-1:0]      o_negative_level,
  output ccl_channel_levels_type      o_channel_levels,
  output logic                        o_positive_pin,
  output logic                        o_negative_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pad voltages settle one clock after they are requested
  always_ff @(posedge i_clk) begin
    o_positive_level <= i_set_pos;
    o_negative_level <= i_set_neg;
    o_channel_levels <= i_set_ch;
  end

  // Pads read high above mid-scale
  assign o_positive_pin = o_positive_level[CCL_LEVEL_W-1];
  assign o_negative_pin = o_negative_level[CCL_LEVEL_W-1];
endmodule : ccl_analog_model

`default_nettype wire

// ### dv/ccl_comparator_control_sva.sv
// Port checker for the comparator control logic
`default_nettype none

module ccl_comparator_control_sva
  import ccl_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  input wire logic [CCL_ADDR_W-1:0] i_addr,
  input wire logic [CCL_DATA_W-1:0] i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [CCL_DATA_W-1:0] o_rdata,
  input wire logic                  i_global_irq_enable,
  input wire logic                  i_irq_vector_ack,
  input wire logic [1:0]            o_pin_inputs,
  input wire logic [1:0]            o_buffer_off,
  input wire logic                  o_comparator_power_off,
  input wire logic                  o_bandgap_select,
  input wire logic                  o_irq_request,
  input wire logic [CCL_DATA_W-1:0] o_analog_control_b,
  input wire logic [CCL_DATA_W-1:0] o_digital_input_disable
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // ********
  // Register bus
  // ********
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  property p_rd_resv;
    $past(i_rd) && $past(i_addr) == 5'h08 |-> o_rdata[2] == 1'b0;
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved bit read high");
  property p_wr_acb;
    i_wr && i_addr == 5'h03 |=> o_analog_control_b == ($past(i_wdata) & 8'he7);
  endproperty
  a_wr_acb: assert property (p_wr_acb) else $error("control b write wrong");
  property p_rd_acb;
    $past(i_rd) && $past(i_addr) == 5'h03 |-> o_rdata == $past(o_analog_control_b);
  endproperty
  a_rd_acb: assert property (p_rd_acb) else $error("control b read wrong");
  property p_wr_did;
    i_wr && i_addr == 5'h14 |=> o_digital_input_disable == ($past(i_wdata) & 8'h3f);
  endproperty
  a_wr_did: assert property (p_wr_did) else $error("input disable write wrong");
  property p_wr_pwr;
    i_wr && i_addr == 5'h08 |=> o_comparator_power_off == $past(i_wdata[7]);
  endproperty
  a_wr_pwr: assert property (p_wr_pwr) else $error("power off bit wrong");
  property p_wr_bg;
    i_wr && i_addr == 5'h08 |=> o_bandgap_select == $past(i_wdata[6]);
  endproperty
  a_wr_bg: assert property (p_wr_bg) else $error("bandgap select wrong");

  // ********
  // Pads and interrupt
  // ********
  property p_pin_off;
    o_buffer_off == o_digital_input_disable[1:0] &&
    (o_pin_inputs & o_buffer_off & $past(o_buffer_off)) == 2'h0;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pad reads high");
  property p_irq_gie;
    o_irq_request |-> i_global_irq_enable;
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("request without global enable");
  property p_irq_drop;
    $fell(o_irq_request) && i_global_irq_enable |->
      $past(i_irq_vector_ack) || $past(i_wr && i_addr == 5'h08);
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request dropped unprompted");
endmodule : ccl_comparator_control_sva

bind ccl_comparator_control ccl_comparator_control_sva u_sva (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_enable(i_global_irq_enable),
  .i_irq_vector_ack(i_irq_vector_ack), .o_pin_inputs(o_pin_inputs),
  .o_buffer_off(o_buffer_off), .o_comparator_power_off(o_comparator_power_off),
  .o_bandgap_select(o_bandgap_select), .o_irq_request(o_irq_request),
  .o_analog_control_b(o_analog_control_b), .o_digital_input_disable(o_digital_input_disable)
);

`default_nettype wire

// ### dv/comparator_control_logic_tb.sv
// Self-checking bench for the comparator control logic
`default_nettype none

module comparator_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccl_pkg::*;

  logic                   clk, rst, wr, rd, conv, gie, ack, pp, np, pwr, bg, irq;
  logic [CCL_ADDR_W-1:0]  addr;
  logic [7:0]             wdata, rdata, acb_o, did_o;
  logic [1:0]             sel, pins, boff;
  logic [CCL_LEVEL_W-1:0] set_pos, set_neg, pos_l, neg_l;
  ccl_channel_levels_type set_ch, ch_l;
  logic [31:0]            seed;
  int                     error_cnt, checked, cyc;

  // ********
  // Clock, model and design
  // ********
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ccl_analog_model u_model (.i_clk(clk), .i_set_pos(set_pos), .i_set_neg(set_neg),
    .i_set_ch(set_ch), .o_positive_level(pos_l), .o_negative_level(neg_l),
    .o_channel_levels(ch_l), .o_positive_pin(pp), .o_negative_pin(np));

  ccl_comparator_control dut (.i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_positive_level(pos_l),
    .i_negative_level(neg_l), .i_channel_levels(ch_l), .i_converter_enable(conv),
    .i_channel_select(sel), .i_global_irq_enable(gie), .i_irq_vector_ack(ack),
    .i_positive_pin(pp), .i_negative_pin(np), .o_pin_inputs(pins), .o_buffer_off(boff),
    .o_comparator_power_off(pwr), .o_bandgap_select(bg), .o_irq_request(irq),
    .o_analog_control_b(acb_o), .o_digital_input_disable(did_o));

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  function automatic logic exp_res(input logic pw, input logic bs, input logic mux);
    logic [CCL_LEVEL_W-1:0] p;
    logic [CCL_LEVEL_W-1:0] n;
    p = bs ? CCL_BANDGAP_LEVEL : set_pos;
    n = (mux && !conv) ? set_ch[sel] : set_neg;
    return !pw && (p > n);
  endfunction : exp_res

  task automatic final_report();
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    logic [31:0] r;
    logic [63:0] q;
    logic [7:0]  d, acb, did, ccs;
    logic [1:0]  md;
    logic        up, dn;
    {rst, wr, rd, conv, gie, ack, addr, wdata, sel} = '0;
    {set_pos, set_neg, set_ch, error_cnt, checked, cyc} = '0;
    seed = 32'd46788;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset contents and an unmapped place
    rd_reg(5'h03, d); chk8("acb_rst", 8'h00, d);
    rd_reg(5'h14, d); chk8("did_rst", 8'h00, d);
    rd_reg(5'h08, d); chk8("ccs_rst", 8'h00, d);
    rd_reg(5'h1f, d); chk8("unmapped", 8'h00, d);
    // Random routing, power and pad configurations; irq enable kept off
    for (int i = 0; i < 24; i++) begin
      r = next_rand();
      q = {next_rand(), next_rand()};
      set_pos <= r[9:0];
      set_neg <= r[19:10];
      set_ch <= q[39:0];
      conv <= r[20];
      sel <= r[22:21];
      acb = r[31:24];
      did = q[47:40];
      ccs = {r[23], r[25], 6'h04};
      wr_reg(5'h03, acb);
      wr_reg(5'h14, did);
      wr_reg(5'h08, ccs);
      repeat (8) @(posedge clk);
      rd_reg(5'h03, d); chk8("acb", acb & 8'he7, d);
      rd_reg(5'h14, d); chk8("did", did & 8'h3f, d);
      rd_reg(5'h08, d);
      chk8("ccs", {ccs[7:6], exp_res(ccs[7], ccs[6], acb[6]), 5'h00}, d & 8'hef);
      chk1("pwr", ccs[7], pwr);
      chk1("bg", ccs[6], bg);
      chk8("acb_o", acb & 8'he7, acb_o);
      chk8("did_o", did & 8'h3f, did_o);
      chk8("pins", {6'h00, {set_neg[9], set_pos[9]} & ~did[1:0]}, {6'h00, pins});
      chk8("boff", {6'h00, did[1:0]}, {6'h00, boff});
    end
    // Event modes on both edges
    wr_reg(5'h03, 8'h00);
    wr_reg(5'h08, 8'h10);
    gie <= 1'b1;
    set_pos <= 10'h100;
    set_neg <= 10'h200;
    repeat (8) @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      md = m[1:0];
      up = (md == 2'h0) || (md == 2'h3);
      dn = (md == 2'h0) || (md == 2'h2);
      wr_reg(5'h08, {6'h04, md});
      wr_reg(5'h08, {6'h06, md});
      set_pos <= 10'h300;
      repeat (8) @(posedge clk);
      rd_reg(5'h08, d); chk8("ccs_up", {3'h1, up, 2'h2, md}, d);
      chk1("irq", up, irq);
      @(posedge clk);
      gie <= 1'b0;
      #1 chk1("irq_gie", 1'b0, irq);
      @(posedge clk);
      gie <= 1'b1;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      #1 chk1("irq_ack", 1'b0, irq);
      wr_reg(5'h08, {6'h04, md});
      set_pos <= 10'h100;
      repeat (8) @(posedge clk);
      rd_reg(5'h08, d); chk8("ccs_dn", {3'h0, dn, 2'h0, md}, d);
      wr_reg(5'h08, {6'h00, md});
      rd_reg(5'h08, d); chk8("ccs_w0", {3'h0, dn, 2'h0, md}, d);
      wr_reg(5'h08, {6'h04, md});
      rd_reg(5'h08, d); chk8("ccs_w1", {6'h00, md}, d);
    end
    final_report();
  end
endmodule : comparator_control_logic_tb

`default_nettype wire
